// ===== hdl/adc_seq_pkg.sv
package adc_seq_pkg;
    // Register word indices; byte address is four times the index
    localparam logic [9:0] FLAG_IDX = 10'h00c;
    localparam logic [9:0] RESULT_IDX = 10'h01e;
    localparam logic [9:0] CTRL_IDX = 10'h01f;
    localparam logic [9:0] CFG_IDX = 10'h09f;

    // converter_control field positions
    localparam int CLK_SEL_LSB = 6;
    localparam int CHAN_LSB = 3;
    localparam int GO_BIT = 2;
    localparam int ON_BIT = 0;
    // Done flag position inside the flag register
    localparam int FLAG_BIT = 6;

    // Reset values
    localparam logic [1:0] CLK_SEL_RST = 2'h0;
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic [2:0] PCFG_RST = 3'h0;
    localparam logic [7:0] SAR_RST = 8'h00;

    // Conversion clock select codes
    localparam logic [1:0] CLK_DIV2 = 2'h0;
    localparam logic [1:0] CLK_DIV8 = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [1:0] CLK_RC = 2'h3;

    // Half-period of the bit clock, in system clocks, per divider code
    localparam logic [3:0] HALF_DIV2 = 4'h1;
    localparam logic [3:0] HALF_DIV8 = 4'h4;
    localparam logic [4:0] HALF_DIV32 = 5'h10;

    // Conversion: 9.5 bit periods = 19 half periods; recovery: 2 periods
    localparam logic [4:0] CONV_HALVES = 5'd19;
    localparam logic [4:0] RECOV_HALVES = 5'd4;
    localparam logic [7:0] SAR_FIRST = 8'h80;

    // Highest legal channel code
    localparam logic [2:0] CHAN_MAX = 3'h4;

    // Pin function table: {reference from pin, analog mask AN4..AN0}
    localparam logic [7:0][5:0] PIN_MAP = {
        6'b0_00000, 6'b1_00000, 6'b1_01011, 6'b0_00011,
        6'b1_00011, 6'b0_01011, 6'b1_11111, 6'b0_11111
    };

    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_RECOV} conv_state_t;
endpackage

// ===== hdl/adc_sequencer_control.sv
// Our own choice: the AHB-Lite interface to the registers.
module adc_sequencer_control
    import adc_seq_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_sleep,
    input wire logic i_rc_tick,
    input wire logic i_comparator,
    output logic o_converter_on,
    output logic [2:0] o_channel,
    output logic o_ref_from_pin,
    output logic [4:0] o_analog_pins,
    output logic o_hold_connect,
    output logic [7:0] o_dac_code,
    output logic o_conversion_done_flag
);
    import adc_seq_pkg::*;

    typedef struct packed {
        conv_state_t state;
        logic on;
        logic go;
        logic [1:0] clk_sel;
        logic [2:0] chan;
        logic [2:0] pcfg;
        logic flag;
        logic [4:0] half_cnt;
        logic [4:0] div_cnt;
        logic [7:0] sar;
        logic [2:0] bit_idx;
        logic wr_pend;
        logic [9:0] wr_idx;
        logic [31:0] rdata;
    } seq_state_t;

    seq_state_t s_q;
    seq_state_t s_d;
    logic [7:0] result_q;
    logic result_load;
    logic half_tick;
    logic [4:0] half_len;
    logic addr_ok;
    logic take;

    // Address phase decode; only aligned words in the low 4 KB map
    assign take = i_hsel & i_htrans[1] & i_hready;
    assign addr_ok = (i_haddr[31:12] == 20'h00000) & (i_haddr[1:0] == 2'h0);

    // Bit clock half period; RC tick comes from outside as an enable
    always_comb
    begin
        case (s_q.clk_sel)
            CLK_DIV2: half_len = {1'b0, HALF_DIV2};
            CLK_DIV8: half_len = {1'b0, HALF_DIV8};
            default: half_len = HALF_DIV32;
        endcase
    end

    // Oscillator stops in sleep, so only the RC source ticks then
    always_comb
    begin
        if (s_q.clk_sel == CLK_RC)
            half_tick = i_rc_tick;
        else
            // Compare with >= so a count left high by sleep or a clock
            // change ticks at once instead of wrapping for 32 cycles
            half_tick = !i_sleep && (s_q.div_cnt >= half_len - 5'd1);
    end

    // Next-state logic: bus writes, sequencing, read data
    always_comb
    begin
        logic [7:0] wb;
        logic [7:0] ctrl_rd;
        wb = i_hwdata[7:0];
        ctrl_rd = 8'h00;
        s_d = s_q;
        result_load = 1'b0;
        s_d.wr_pend = 1'b0;

        // Divider runs only while busy, restarts on each half tick
        if (s_q.state == ST_IDLE || half_tick)
            s_d.div_cnt = 5'd0;
        else
            s_d.div_cnt = s_q.div_cnt + 5'd1;

        // Data phase of a write
        if (s_q.wr_pend)
        begin
            case (s_q.wr_idx)
                CTRL_IDX:
                begin
                    s_d.clk_sel = wb[CLK_SEL_LSB +: 2];
                    s_d.chan = wb[CHAN_LSB +: 3];
                    s_d.on = wb[ON_BIT];
                    // Go only takes when already on; bit 1 is dropped
                    if (wb[GO_BIT] && s_q.on && wb[ON_BIT])
                        s_d.go = 1'b1;
                    else if (!wb[GO_BIT])
                        s_d.go = 1'b0;
                end
                CFG_IDX: s_d.pcfg = wb[2:0];
                FLAG_IDX: s_d.flag = wb[FLAG_BIT];
                default: ;
            endcase
        end

        // Conversion sequencing
        case (s_q.state)
            ST_IDLE:
            begin
                s_d.half_cnt = 5'd0;
                if (s_d.go && s_d.on)
                begin
                    s_d.state = ST_CONV;
                    s_d.sar = SAR_FIRST;
                    s_d.bit_idx = 3'd7;
                end
            end
            ST_CONV:
            begin
                if (!s_d.on || !s_d.go)
                begin
                    // Clearing go or on abandons the conversion
                    s_d.state = ST_IDLE;
                    s_d.go = 1'b0;
                end
                else if (half_tick)
                begin
                    s_d.half_cnt = s_q.half_cnt + 5'd1;
                    // Decide one bit at the end of each of the first eight full periods
                    if (s_q.half_cnt[0] && s_q.half_cnt < 5'd16)
                    begin
                        s_d.sar[s_q.bit_idx] = i_comparator;
                        if (s_q.bit_idx != 3'd0)
                            s_d.sar[s_q.bit_idx - 3'd1] = 1'b1;
                        s_d.bit_idx = s_q.bit_idx - 3'd1;
                    end
                    if (s_q.half_cnt == CONV_HALVES - 5'd1)
                    begin
                        result_load = 1'b1;
                        s_d.go = 1'b0;
                        s_d.state = ST_RECOV;
                        s_d.half_cnt = 5'd0;
                    end
                end
            end
            ST_RECOV:
            begin
                // Hold stays off two bit periods before acquiring again
                if (!s_d.on)
                    s_d.state = ST_IDLE;
                else if (half_tick)
                begin
                    s_d.half_cnt = s_q.half_cnt + 5'd1;
                    if (s_q.half_cnt == RECOV_HALVES - 5'd1)
                        s_d.state = ST_IDLE;
                end
            end
            default: s_d.state = ST_IDLE;
        endcase

        // Set wins over a clear written in the same cycle
        if (result_load)
            s_d.flag = 1'b1;

        // Address phase: latch write target, fetch read data
        if (take && addr_ok && i_hwrite)
        begin
            s_d.wr_pend = 1'b1;
            s_d.wr_idx = i_haddr[11:2];
        end
        ctrl_rd = {s_d.clk_sel, s_d.chan, s_d.go, 1'b0, s_d.on};
        s_d.rdata = 32'h00000000;
        if (take && addr_ok && !i_hwrite)
        begin
            case (i_haddr[11:2])
                CTRL_IDX: s_d.rdata[7:0] = ctrl_rd;
                CFG_IDX: s_d.rdata[2:0] = s_d.pcfg;
                FLAG_IDX: s_d.rdata[FLAG_BIT] = s_d.flag;
                RESULT_IDX: s_d.rdata[7:0] = result_load ? s_d.sar : result_q;
                default: ;
            endcase
        end
    end

    // Control state, cleared by any reset
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            s_q.state <= ST_IDLE;
            s_q.on <= 1'b0;
            s_q.go <= 1'b0;
            s_q.clk_sel <= CLK_SEL_RST;
            s_q.chan <= CHAN_RST;
            s_q.pcfg <= PCFG_RST;
            s_q.flag <= 1'b0;
            s_q.half_cnt <= 5'd0;
            s_q.div_cnt <= 5'd0;
            s_q.sar <= SAR_RST;
            s_q.bit_idx <= 3'd0;
            s_q.wr_pend <= 1'b0;
            s_q.wr_idx <= 10'h000;
            s_q.rdata <= 32'h00000000;
        end
        else
            s_q <= s_d;
    end

    // Result has no reset, so it keeps its content across resets
    always_ff @(posedge i_clock)
    begin
        if (result_load)
            result_q <= s_d.sar;
    end

    // Outputs; channel codes above four fall back to the first input
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = s_q.rdata;
    assign o_converter_on = s_q.on;
    assign o_channel = (s_q.chan > CHAN_MAX) ? 3'h0 : s_q.chan;
    assign o_ref_from_pin = PIN_MAP[s_q.pcfg][5];
    assign o_analog_pins = PIN_MAP[s_q.pcfg][4:0];
    assign o_hold_connect = s_q.on && (s_q.state == ST_IDLE);
    assign o_dac_code = s_q.sar;
    assign o_conversion_done_flag = s_q.flag;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    // Conversion length checker
    logic [5:0] conv_halves;
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            conv_halves <= 6'd0;
        else if (s_q.state != ST_CONV)
            conv_halves <= 6'd0;
        else if (half_tick)
            conv_halves <= conv_halves + 6'd1;
    end

    chk_conv_halves: assert property (
        s_q.state == ST_CONV && $past(s_q.state) == ST_CONV |->
        conv_halves <= 6'd19)
        else $error("conversion ran past nineteen half periods");
    chk_done_effects: assert property (
        result_load |=> !s_q.go && s_q.flag && s_q.state == ST_RECOV)
        else $error("completion did not clear go and set flag");
    chk_result_value: assert property (
        result_load |=> result_q == $past(s_d.sar))
        else $error("result register not loaded");
    chk_go_busy: assert property (
        s_q.state == ST_CONV |-> s_q.go && s_q.on)
        else $error("busy without go and on");
    chk_hold_open: assert property (
        s_q.state != ST_IDLE |-> !o_hold_connect)
        else $error("hold connected during conversion");
    chk_recov_gap: assert property (
        s_q.state == ST_IDLE && $past(s_q.state) == ST_RECOV && s_q.on |->
        $past(s_q.half_cnt) == 5'd3)
        else $error("recovery shorter than two periods");
    chk_fast_tick: assert property (
        s_q.state == ST_CONV && s_q.clk_sel == CLK_DIV2 && !i_sleep |->
        half_tick)
        else $error("divide by two did not tick every clock");
    chk_sleep_stall: assert property (
        i_sleep && s_q.clk_sel != CLK_RC |-> !half_tick)
        else $error("oscillator clock ticked in sleep");
    chk_off_idle: assert property (
        !s_q.on |=> s_q.state != ST_CONV || s_q.on)
        else $error("converting while switched off");
    chk_unimpl_zero: assert property (
        $past(take && addr_ok && !i_hwrite && i_haddr[11:2] == CTRL_IDX) |->
        o_hrdata[1] == 1'b0)
        else $error("unimplemented control bit read one");
    chk_chan_route: assert property (
        s_q.chan <= CHAN_MAX |-> o_channel == s_q.chan)
        else $error("channel not routed");

    cov_complete: cover property (result_load);
    cov_rc_sleep: cover property (i_sleep && result_load);
    cov_abort: cover property (s_q.state == ST_CONV ##1 s_q.state == ST_IDLE);
    cov_div32: cover property (result_load && s_q.clk_sel == CLK_DIV32);
endmodule

// ===== tb/testbench.sv
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_seq_pkg::*;

    localparam logic [31:0] A_CTRL = {20'h00000, CTRL_IDX, 2'h0};
    localparam logic [31:0] A_CFG = {20'h00000, CFG_IDX, 2'h0};
    localparam logic [31:0] A_FLAG = {20'h00000, FLAG_IDX, 2'h0};
    localparam logic [31:0] A_RES = {20'h00000, RESULT_IDX, 2'h0};
    // Expected {reference from pin, analog mask} per pin config code
    localparam logic [5:0] PIN_EXP [8] = '{6'h1f, 6'h3f, 6'h0b, 6'h23,
        6'h03, 6'h2b, 6'h20, 6'h00};
    localparam int HALF [3] = '{1, 4, 16};
    localparam logic [7:0] LVL [3] = '{8'hff, 8'h00, 8'h5a};

    logic i_clock = 1'h0;
    logic i_sys_rst = 1'h1;
    logic i_hsel = 1'h0;
    logic i_hwrite = 1'h0;
    logic i_sleep = 1'h0;
    logic i_rc_tick = 1'h0;
    logic [31:0] i_haddr = 32'h0;
    logic [31:0] i_hwdata = 32'h0;
    logic [1:0] i_htrans = 2'h0;
    logic [1:0] rc_cnt = 2'h0;
    logic [7:0] level = 8'h00;
    wire logic i_hready;
    wire logic i_comparator;
    wire logic o_hreadyout, o_hresp, o_converter_on, o_ref_from_pin;
    wire logic o_hold_connect, o_conversion_done_flag;
    wire logic [31:0] o_hrdata;
    wire logic [2:0] o_channel;
    wire logic [4:0] o_analog_pins;
    wire logic [7:0] o_dac_code;
    int miscompares = 0;
    int num_checks = 0;

    always #12.5 i_clock = ~i_clock;

    // Free-running RC clock: one half-period tick every third cycle
    always @(posedge i_clock)
    begin
        rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
        i_rc_tick <= (rc_cnt == 2'h2);
    end

    // Ideal comparator against the trial word; single slave drives hready
    assign i_comparator = (level >= o_dac_code);
    assign i_hready = o_hreadyout;

    adc_sequencer_control DUT (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(i_hready),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
        .i_sleep(i_sleep), .i_rc_tick(i_rc_tick),
        .i_comparator(i_comparator), .o_converter_on(o_converter_on),
        .o_channel(o_channel), .o_ref_from_pin(o_ref_from_pin),
        .o_analog_pins(o_analog_pins), .o_hold_connect(o_hold_connect),
        .o_dac_code(o_dac_code),
        .o_conversion_done_flag(o_conversion_done_flag)
    );

    task automatic summarize;
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Bounded wait for hready; a hang ends the run
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge i_clock);
            n++;
        end
        while (i_hready !== 1'h1 && n < 20);
        if (n >= 20)
        begin
            miscompares++;
            summarize();
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        i_hsel <= 1'h1;
        i_haddr <= a;
        i_htrans <= 2'h2;
        i_hwrite <= wr;
        wait_rdy();
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        wait_rdy();
        rd = o_hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'h1, a, d, r);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'h0, a, 32'h0, r);
        `CHK(r, e)
    endtask

    task automatic tick;
        @(posedge i_clock);
        #1;
    endtask

    // One conversion on channel 2; half=0 skips the timing checks
    task automatic run_conv(input logic [1:0] sel, input logic [7:0] lvl,
        input int half);
        int n;
        logic [31:0] c;
        c = {24'h0, sel, 3'h2, 3'h1};
        level <= lvl;
        wr(A_CTRL, c);
        // Let the channel settle before starting
        repeat (4) @(posedge i_clock);
        wr(A_CTRL, c | 32'h4);
        n = 0;
        while (o_conversion_done_flag !== 1'h1 && n < 2000)
        begin
            tick();
            n++;
            if (n == 1) `CHK(o_hold_connect, 1'h0)
        end
        // A conversion that never ends is a failure, not a pass
        if (n >= 2000)
        begin
            miscompares++;
            summarize();
        end
        if (half > 0)
        begin
            `CHK(n, 19 * half)
            repeat (4 * half - 1) tick();
            `CHK(o_hold_connect, 1'h0)
            tick();
            `CHK(o_hold_connect, 1'h1)
        end
        @(posedge i_clock);
        rd_chk(A_RES, {24'h0, lvl});
        rd_chk(A_CTRL, c);
        rd_chk(A_FLAG, 32'h1 << FLAG_BIT);
        wr(A_FLAG, 32'h0);
        rd_chk(A_FLAG, 32'h0);
    endtask

    initial
    begin
        repeat (4) @(posedge i_clock);
        i_sys_rst <= 1'h0;
        @(posedge i_clock);
        rd_chk(A_CTRL, 32'h0);
        rd_chk(A_CFG, 32'h0);
        rd_chk(A_FLAG, 32'h0);
        rd_chk(32'h0000_0100, 32'h0);
        // Go in the same write as on is dropped; bit 1 never sticks
        wr(A_CTRL, 32'hff);
        rd_chk(A_CTRL, 32'hf9);
        wr(A_CTRL, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            wr(A_CFG, 32'(i));
            #1;
            `CHK({o_ref_from_pin, o_analog_pins}, PIN_EXP[i])
            @(posedge i_clock);
            rd_chk(A_CFG, 32'(i));
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(A_CTRL, 32'(i) << CHAN_LSB);
            #1;
            `CHK(o_channel, (i < 5) ? 3'(i) : 3'h0)
            @(posedge i_clock);
        end
        wr(A_CFG, 32'h0);
        for (int s = 0; s < 3; s++)
            run_conv(2'(s), LVL[s], HALF[s]);
        i_sleep <= 1'h1;
        run_conv(CLK_RC, 8'ha5, 0);
        // Oscillator divider stalls while asleep
        wr(A_CTRL, 32'h01);
        wr(A_CTRL, 32'h05);
        repeat (40) tick();
        `CHK(o_conversion_done_flag, 1'h0)
        @(posedge i_clock);
        i_sleep <= 1'h0;
        repeat (30) tick();
        `CHK(o_conversion_done_flag, 1'h1)
        @(posedge i_clock);
        wr(A_FLAG, 32'h0);
        // Abort by switching off mid-conversion
        wr(A_CTRL, 32'h81);
        wr(A_CTRL, 32'h85);
        rd_chk(A_CTRL, 32'h85);
        wr(A_CTRL, 32'h80);
        repeat (330) tick();
        `CHK(o_conversion_done_flag, 1'h0)
        `CHK(o_converter_on, 1'h0)
        // Reset in mid-conversion keeps the old result
        @(posedge i_clock);
        wr(A_CTRL, 32'h81);
        wr(A_CTRL, 32'h85);
        repeat (10) @(posedge i_clock);
        i_sys_rst <= 1'h1;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'h0;
        #1;
        `CHK(o_converter_on, 1'h0)
        `CHK({o_hresp, o_hreadyout}, 2'h1)
        @(posedge i_clock);
        rd_chk(A_CTRL, 32'h0);
        repeat (330) @(posedge i_clock);
        rd_chk(A_FLAG, 32'h0);
        rd_chk(A_RES, 32'ha5);
        summarize();
    end
endmodule
